// ### clsc_pkg.sv
// Constants and types shared by the camera link status and control block.
`default_nettype none
package clsc_pkg;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int unsigned CLK_FREQ_HZ      = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 40;
    localparam int unsigned SLOW_FLASH_HZ    = 1;
    localparam int unsigned FAST_FLASH_HZ    = 8;
    localparam int unsigned SLOW_HALF_CYC    = CLK_FREQ_HZ / (2 * SLOW_FLASH_HZ);
    localparam int unsigned FAST_HALF_CYC    = CLK_FREQ_HZ / (2 * FAST_FLASH_HZ);
    localparam int unsigned PULSE_RES_NS     = 20;
    localparam int unsigned PULSE_RES_RAW    = (PULSE_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_RES_CYC    = (PULSE_RES_RAW > 0) ? PULSE_RES_RAW : 1;
    localparam int unsigned PCLK_TIMEOUT_NS  = 10_000;
    localparam int unsigned PCLK_TIMEOUT_CYC = PCLK_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned LVAL_TIMEOUT_US  = 1_000;
    localparam int unsigned LVAL_TIMEOUT_CYC = (LVAL_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

    // ***************************************************************
    // Host link status codes
    // ***************************************************************
    localparam logic [1:0] LINK_GEN3     = 2'h3;
    localparam logic [4:0] LINK_LANES_X4 = 5'h04;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned PERIOD_W    = 24;
    localparam int unsigned PULSE_W     = 16;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_CC_SEL  = 8'h08;
    localparam logic [7:0]  OFS_PERIOD  = 8'h0c;
    localparam logic [7:0]  OFS_PULSE0  = 8'h10;
    localparam logic [7:0]  OFS_PULSE1  = 8'h14;
    localparam int unsigned CTRL_WIDTH_LSB  = 0;
    localparam int unsigned CTRL_PWR_LSB    = 2;
    localparam int unsigned STAT_PCLK_LSB   = 0;
    localparam int unsigned STAT_LVAL_LSB   = 3;
    localparam int unsigned STAT_PWR_LSB    = 6;
    localparam int unsigned STAT_LAMP1_LSB  = 8;
    localparam int unsigned STAT_LAMP2_LSB  = 10;
    localparam int unsigned CC_SEL_W        = 3;
    localparam int unsigned PULSE_DLY_LSB   = 0;
    localparam int unsigned PULSE_WID_LSB   = 16;
    localparam logic [11:0]       CC_SEL_RST = 12'h000;
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 24'h000000;
    localparam logic [31:0]       PULSE_RST  = 32'h00000000;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [1:0] {
        CLSC_CL_BASE   = 2'h0,
        CLSC_CL_MEDIUM = 2'h1,
        CLSC_CL_FULL   = 2'h2,
        CLSC_CL_80BIT  = 2'h3
    } clsc_cl_width_t;

    localparam clsc_cl_width_t WIDTH_RST = CLSC_CL_MEDIUM;

    typedef enum logic [2:0] {
        CLSC_CC_UNUSED = 3'h0,
        CLSC_CC_PULSE0 = 3'h1,
        CLSC_CC_PULSE1 = 3'h2,
        CLSC_CC_HIGH   = 3'h3,
        CLSC_CC_LOW    = 3'h4
    } clsc_cc_sel_t;

    typedef enum logic [1:0] {
        CLSC_LAMP_RED   = 2'h0,
        CLSC_LAMP_GREEN = 2'h1,
        CLSC_LAMP_SLOW  = 2'h3,
        CLSC_LAMP_FAST  = 2'h2
    } clsc_cam_state_t;

    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } clsc_rgb_t;

    typedef struct packed {
        logic       trained;
        logic       fail;
        logic [1:0] gen;
        logic [4:0] lanes;
    } clsc_link_stat_t;

    typedef struct packed {
        logic [2:0] lval;
        logic [2:0] pclk;
    } clsc_cam_pins_t;

endpackage : clsc_pkg
`default_nettype wire

// ### clsc_blink.sv
// Free-running divider that toggles a flash level every half period.
`timescale 1ns/1ns
`default_nettype none
module clsc_blink #(
    parameter int unsigned HALF_CYC = 12_500_000
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output var  logic level_o
);

    localparam int unsigned CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_q;
    logic          level_q;

    // (R22) even on/off
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q   <= '0;
            level_q <= 1'b0;
        end
        else if (cnt_q == LAST)
        begin
            cnt_q   <= '0;
            level_q <= ~level_q;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign level_o = level_q;

endmodule : clsc_blink
`default_nettype wire

// ### clsc_activity.sv
// Synchronises a camera signal and reports whether it toggled recently.
`timescale 1ns/1ns
`default_nettype none
module clsc_activity #(
    parameter int unsigned TIMEOUT_CYC = 250
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic sig_i,
    output var  logic active_o
);

    localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] FULL = CW'(TIMEOUT_CYC);

    logic          meta_q;
    logic          sync_q;
    logic          prev_q;
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= sig_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Any edge reloads the window; silence for the whole window clears it.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (sync_q != prev_q)
            cnt_q <= FULL;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    assign active_o = (cnt_q != '0);

endmodule : clsc_activity
`default_nettype wire

// ### clsc_top.sv
// Board and camera lamps, camera power hold and camera control outputs.
//
// Summary of operation
// (R1) No logic image configured: board lamp solid red.
// (R2) Normal image, third generation, four lanes: solid green.
// (R3) Normal image, first or second generation, four lanes: flashing green.
// (R4) Normal image, third generation, other width: solid yellow.
// (R5) Normal image, first or second generation, other width: flashing yellow.
// (R6) Safe image: blue, solid at third generation, else flashing.
// (R7) Host link training failed: board lamp flashes red.
// (R8) Camera lamp solid red while no pixel clock is detected.
// (R9) Pixel clock but no line valid: camera lamp solid green.
// (R10) Clock and line valid: slow green flash; acquiring: fast flash.
// (R11) Second lamp in full width needs both second-cable clocks and line valids.
// (R12) Full or 80-bit needs two clocks, two line valids; base: not applicable.
// (R13) First connector and medium second connector need one clock, one line valid.
// (R14) First connector at base width keeps the second lamp red.
// (R15) The two camera lamps are driven independently.
// (R16) Camera interface width resets to medium.
// (R17) Camera power, once enabled, holds until reset.
// (R18) Each control output: pulse generator, static high, static low or unused.
// (R19) Pulse generator times in 20 ns resolution units; here one unit is one 40 ns clock cycle.
// (R20) Internal line trigger period is programmable in 20 ns units; here it counts 40 ns clock cycles.
// (R21) Medium and full cameras are cabled to both connectors.
// (R22) Flashing lamps toggle with even on and off time from a divider.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module clsc_top #(
    parameter int unsigned SLOW_HALF_CYC    = clsc_pkg::SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF_CYC    = clsc_pkg::FAST_HALF_CYC,
    parameter int unsigned LVAL_TIMEOUT_CYC = clsc_pkg::LVAL_TIMEOUT_CYC
) (
    input  wire logic                            clk_i,
    input  wire logic                            rst_n_i,
    input  wire logic [clsc_pkg::ADDR_W-1:0]     addr_i,
    input  wire logic [clsc_pkg::DATA_W-1:0]     wdata_i,
    input  wire logic                            wr_i,
    input  wire logic                            rd_i,
    output var  logic [clsc_pkg::DATA_W-1:0]     rdata_o,
    input  wire logic                            image_loaded_i,
    input  wire logic                            safe_image_i,
    input  wire clsc_pkg::clsc_link_stat_t       link_i,
    input  wire clsc_pkg::clsc_cam_pins_t        cam_i,
    input  wire logic [1:0]                      acq_active_i,
    output var  clsc_pkg::clsc_rgb_t             board_lamp_o,
    output var  clsc_pkg::clsc_rgb_t             first_camera_lamp_o,
    output var  clsc_pkg::clsc_rgb_t             second_camera_lamp_o,
    output var  logic [1:0]                      cam_power_o,
    output var  logic [3:0]                      cc_o,
    output var  logic                            line_trig_o
);

    localparam int unsigned RES_W = $clog2(clsc_pkg::PULSE_RES_CYC + 1);
    localparam logic [RES_W-1:0] RES_LAST = RES_W'(clsc_pkg::PULSE_RES_CYC - 1);
    localparam int unsigned PW = clsc_pkg::PULSE_W;

    // ***************************************************************
    // Functions
    // ***************************************************************

    // Maps detection results of one connector to its lamp state.
    function automatic clsc_pkg::clsc_cam_state_t cam_state(
        input logic pclk_ok,
        input logic lval_ok,
        input logic acq
    );
        clsc_pkg::clsc_cam_state_t st;
        st = clsc_pkg::CLSC_LAMP_RED;
        if (pclk_ok && lval_ok && acq)
            st = clsc_pkg::CLSC_LAMP_FAST;
        else if (pclk_ok && lval_ok)
            st = clsc_pkg::CLSC_LAMP_SLOW;
        else if (pclk_ok)
            st = clsc_pkg::CLSC_LAMP_GREEN;
        return st;
    endfunction : cam_state

    // Turns a lamp state into colour bits using the two flash levels.
    function automatic clsc_pkg::clsc_rgb_t cam_rgb(
        input clsc_pkg::clsc_cam_state_t st,
        input logic                      slow,
        input logic                      fast
    );
        clsc_pkg::clsc_rgb_t c;
        c = '0;
        unique case (st)
            clsc_pkg::CLSC_LAMP_RED:   c.red   = 1'b1;
            clsc_pkg::CLSC_LAMP_GREEN: c.green = 1'b1;
            clsc_pkg::CLSC_LAMP_SLOW:  c.green = slow;
            clsc_pkg::CLSC_LAMP_FAST:  c.green = fast;
        endcase
        return c;
    endfunction : cam_rgb

    // Selects the level of one camera control output.
    function automatic logic cc_level(
        input logic [clsc_pkg::CC_SEL_W-1:0] sel,
        input logic                          p0,
        input logic                          p1
    );
        logic v;
        v = 1'b0;
        case (sel)
            clsc_pkg::CLSC_CC_PULSE0: v = p0;
            clsc_pkg::CLSC_CC_PULSE1: v = p1;
            clsc_pkg::CLSC_CC_HIGH:   v = 1'b1;
            default:                  v = 1'b0;
        endcase
        return v;
    endfunction : cc_level

    // ***************************************************************
    // Registers
    // ***************************************************************
    clsc_pkg::clsc_cl_width_t       width_q;
    logic [1:0]                     pwr_q;
    logic [11:0]                    cc_sel_q;
    logic [clsc_pkg::PERIOD_W-1:0]  period_q;
    logic [clsc_pkg::DATA_W-1:0]    pulse_cfg_q [2];
    logic [clsc_pkg::DATA_W-1:0]    rdata_q;
    logic [clsc_pkg::DATA_W-1:0]    rdata_d;
    logic [5:0]                     act;
    clsc_pkg::clsc_cam_state_t      st1;
    clsc_pkg::clsc_cam_state_t      st2;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // (R16) medium by default
            width_q        <= clsc_pkg::WIDTH_RST;
            cc_sel_q       <= clsc_pkg::CC_SEL_RST;
            period_q       <= clsc_pkg::PERIOD_RST;
            pulse_cfg_q[0] <= clsc_pkg::PULSE_RST;
            pulse_cfg_q[1] <= clsc_pkg::PULSE_RST;
        end
        else if (wr_i)
        begin
            case (addr_i)
                clsc_pkg::OFS_CTRL:
                    width_q <= clsc_pkg::clsc_cl_width_t'(wdata_i[clsc_pkg::CTRL_WIDTH_LSB +: 2]);
                clsc_pkg::OFS_CC_SEL:
                    cc_sel_q <= wdata_i[11:0];
                clsc_pkg::OFS_PERIOD:
                    period_q <= wdata_i[clsc_pkg::PERIOD_W-1:0];
                clsc_pkg::OFS_PULSE0:
                    pulse_cfg_q[0] <= wdata_i;
                clsc_pkg::OFS_PULSE1:
                    pulse_cfg_q[1] <= wdata_i;
                default:
                    ;
            endcase
        end
    end

    // (R17) power holds until reset
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pwr_q <= 2'h0;
        else if (wr_i && (addr_i == clsc_pkg::OFS_CTRL))
            pwr_q <= pwr_q | wdata_i[clsc_pkg::CTRL_PWR_LSB +: 2];
    end

    always_comb
    begin
        rdata_d = '0;
        case (addr_i)
            clsc_pkg::OFS_CTRL:
            begin
                rdata_d[clsc_pkg::CTRL_WIDTH_LSB +: 2] = width_q;
                rdata_d[clsc_pkg::CTRL_PWR_LSB +: 2]   = pwr_q;
            end
            clsc_pkg::OFS_STATUS:
            begin
                rdata_d[clsc_pkg::STAT_PCLK_LSB +: 3]  = act[2:0];
                rdata_d[clsc_pkg::STAT_LVAL_LSB +: 3]  = act[5:3];
                rdata_d[clsc_pkg::STAT_PWR_LSB +: 2]   = pwr_q;
                rdata_d[clsc_pkg::STAT_LAMP1_LSB +: 2] = st1;
                rdata_d[clsc_pkg::STAT_LAMP2_LSB +: 2] = st2;
            end
            clsc_pkg::OFS_CC_SEL: rdata_d[11:0] = cc_sel_q;
            clsc_pkg::OFS_PERIOD: rdata_d[clsc_pkg::PERIOD_W-1:0] = period_q;
            clsc_pkg::OFS_PULSE0: rdata_d = pulse_cfg_q[0];
            clsc_pkg::OFS_PULSE1: rdata_d = pulse_cfg_q[1];
            default:              rdata_d = '0;
        endcase
    end

    // Read data stand for the one cycle after the strobe only.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_q <= '0;
        else if (rd_i)
            rdata_q <= rdata_d;
        else
            rdata_q <= '0;
    end

    assign rdata_o     = rdata_q;
    assign cam_power_o = pwr_q;

    // ***************************************************************
    // Activity detection and flash dividers
    // ***************************************************************
    logic [5:0] act_in;
    logic       slow_lvl;
    logic       fast_lvl;

    assign act_in = {cam_i.lval, cam_i.pclk};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_act
            clsc_activity #(
                .TIMEOUT_CYC ((gi < 3) ? clsc_pkg::PCLK_TIMEOUT_CYC : LVAL_TIMEOUT_CYC)
            ) u_act (
                .clk_i    (clk_i),
                .rst_n_i  (rst_n_i),
                .sig_i    (act_in[gi]),
                .active_o (act[gi])
            );
        end
    endgenerate

    clsc_blink #(
        .HALF_CYC (SLOW_HALF_CYC)
    ) u_slow (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .level_o (slow_lvl)
    );

    clsc_blink #(
        .HALF_CYC (FAST_HALF_CYC)
    ) u_fast (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .level_o (fast_lvl)
    );

    // ***************************************************************
    // Camera lamps
    // ***************************************************************
    logic pclk2_ok;
    logic lval2_ok;

    always_comb
    begin
        pclk2_ok = 1'b0;
        lval2_ok = 1'b0;
        unique case (width_q)
            // (R14) base keeps second red
            clsc_pkg::CLSC_CL_BASE:
            begin
                pclk2_ok = 1'b0;
                lval2_ok = 1'b0;
            end
            // (R13) one clock, one valid
            clsc_pkg::CLSC_CL_MEDIUM:
            begin
                pclk2_ok = act[1];
                lval2_ok = act[4];
            end
            // (R11) both second-cable signals
            // (R12) two clocks, two valids
            clsc_pkg::CLSC_CL_FULL, clsc_pkg::CLSC_CL_80BIT:
            begin
                pclk2_ok = act[1] & act[2];
                lval2_ok = act[4] & act[5];
            end
        endcase
    end

    // (R13) first connector detection
    // (R15) lamps are independent
    assign st1 = cam_state(act[0], act[3], acq_active_i[0]);
    assign st2 = cam_state(pclk2_ok, lval2_ok, acq_active_i[1]);

    // (R8) red without clock
    // (R9) green without valid
    // (R10) slow or fast flash
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            first_camera_lamp_o  <= '0;
            second_camera_lamp_o <= '0;
        end
        else
        begin
            first_camera_lamp_o  <= cam_rgb(st1, slow_lvl, fast_lvl);
            second_camera_lamp_o <= cam_rgb(st2, slow_lvl, fast_lvl);
        end
    end

    // ***************************************************************
    // Board status lamp
    // ***************************************************************
    clsc_pkg::clsc_rgb_t board_d;
    logic                gen3;
    logic                x4;

    assign gen3 = (link_i.gen == clsc_pkg::LINK_GEN3);
    assign x4   = (link_i.lanes == clsc_pkg::LINK_LANES_X4);

    always_comb
    begin
        board_d = '0;
        if (!image_loaded_i)
        begin
            // (R1) no image red
            board_d.red = 1'b1;
        end
        else if (link_i.fail || !link_i.trained)
        begin
            // (R7) training failure flashes
            board_d.red = slow_lvl;
        end
        else if (safe_image_i)
        begin
            // (R6) safe image blue
            board_d.blue = gen3 ? 1'b1 : slow_lvl;
        end
        else if (x4)
        begin
            // (R2) gen3 x4 green
            // (R3) slower speed flashes
            board_d.green = gen3 ? 1'b1 : slow_lvl;
        end
        else
        begin
            // (R4) gen3 narrow yellow
            // (R5) slower narrow flashes
            board_d.red   = gen3 ? 1'b1 : slow_lvl;
            board_d.green = gen3 ? 1'b1 : slow_lvl;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            board_lamp_o <= '0;
        else
            board_lamp_o <= board_d;
    end

    // ***************************************************************
    // Resolution tick and internal line trigger
    // ***************************************************************
    logic [RES_W-1:0]              res_cnt_q;
    logic                          res_tick;
    logic [clsc_pkg::PERIOD_W-1:0] line_cnt_q;
    logic                          line_tick;

    // (R19) resolution unit divider
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            res_cnt_q <= '0;
        else if (res_cnt_q == RES_LAST)
            res_cnt_q <= '0;
        else
            res_cnt_q <= res_cnt_q + 1'b1;
    end

    assign res_tick  = (res_cnt_q == RES_LAST);
    assign line_tick = res_tick && (period_q != '0) && (line_cnt_q >= period_q - 1'b1);

    // (R20) programmable trigger period
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            line_cnt_q <= '0;
        else if (period_q == '0)
            line_cnt_q <= '0;
        else if (line_tick)
            line_cnt_q <= '0;
        else if (res_tick)
            line_cnt_q <= line_cnt_q + 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            line_trig_o <= 1'b0;
        else
            line_trig_o <= line_tick;
    end

    // ***************************************************************
    // Pulse generators and camera control outputs
    // ***************************************************************
    logic [PW:0] pcnt_q [2];
    logic [1:0]  prun_q;
    logic [1:0]  pls_q;

    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pulse
            logic [PW-1:0] dly;
            logic [PW:0]   stop;
            assign dly  = pulse_cfg_q[gi][clsc_pkg::PULSE_DLY_LSB +: PW];
            assign stop = {1'b0, dly} + {1'b0, pulse_cfg_q[gi][clsc_pkg::PULSE_WID_LSB +: PW]};

            // (R19) delay and width counting
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    pcnt_q[gi] <= '0;
                    prun_q[gi] <= 1'b0;
                    pls_q[gi]  <= 1'b0;
                end
                else if (line_tick)
                begin
                    pcnt_q[gi] <= '0;
                    prun_q[gi] <= 1'b1;
                    pls_q[gi]  <= 1'b0;
                end
                else if (prun_q[gi] && res_tick)
                begin
                    pls_q[gi] <= (pcnt_q[gi] >= {1'b0, dly}) && (pcnt_q[gi] < stop);
                    if (pcnt_q[gi] >= stop)
                        prun_q[gi] <= 1'b0;
                    else
                        pcnt_q[gi] <= pcnt_q[gi] + 1'b1;
                end
                else if (!prun_q[gi])
                begin
                    pls_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // (R18) per-output source select
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cc_o <= 4'h0;
        else
            for (int i = 0; i < 4; i++)
                cc_o[i] <= cc_level(cc_sel_q[i*clsc_pkg::CC_SEL_W +: clsc_pkg::CC_SEL_W],
                                    pls_q[0], pls_q[1]);
    end

endmodule : clsc_top
`default_nettype wire

// ### clsc_checker.sv
// Assertions on the lamp and camera power outputs.
`timescale 1ns/1ns
`default_nettype none
module clsc_checker (
    input wire logic                      clk_i,
    input wire logic                      rst_n_i,
    input wire logic                      image_loaded_i,
    input wire logic                      safe_image_i,
    input wire clsc_pkg::clsc_link_stat_t link_i,
    input wire clsc_pkg::clsc_rgb_t       board_lamp_o,
    input wire clsc_pkg::clsc_rgb_t       first_camera_lamp_o,
    input wire logic [1:0]                cam_power_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic ok = image_loaded_i && link_i.trained && !link_i.fail;
    wire logic g3 = link_i.gen == 2'h3;
    wire logic x4 = link_i.lanes == 5'h04;
    chk_unloaded_red: assert property (!image_loaded_i |=> board_lamp_o == 3'h4) else $error("no red");
    chk_fast_green: assert property (ok && !safe_image_i && g3 && x4 |=> board_lamp_o == 3'h2) else $error("no green");
    chk_slow_link: assert property (ok && !safe_image_i && !g3 |=> !board_lamp_o.blue && !(x4 && board_lamp_o.red))
        else $error("bad slow link colour");
    chk_narrow_yellow: assert property (ok && !safe_image_i && g3 && !x4 |=> board_lamp_o == 3'h6) else $error("no yellow");
    chk_safe_blue: assert property (ok && safe_image_i && g3 |=> board_lamp_o == 3'h1) else $error("no blue");
    chk_train_fail: assert property (image_loaded_i && link_i.fail |=> board_lamp_o[1:0] == 2'h0) else $error("bad fail");
    chk_power_held: assert property (!$fell(cam_power_o[0]) && !$fell(cam_power_o[1])) else $error("power lost");
    chk_cam_colour: assert property (!first_camera_lamp_o.blue && !(&first_camera_lamp_o[2:1])) else $error("bad lamp");
    cover property (board_lamp_o == 3'h2);
    cover property ($rose(first_camera_lamp_o.green));
    cover property ($rose(cam_power_o[0]));
endmodule : clsc_checker
`default_nettype wire

// ### clsc_cam_model.sv
// Camera model: pixel clocks and line valids per link.
`timescale 1ns/1ns
`default_nettype none
module clsc_cam_model (
    input wire logic [2:0]          pclk_en_i,
    input wire logic [2:0]          lval_en_i,
    output var clsc_pkg::clsc_cam_pins_t pins_o
);
    initial pins_o = '0;
    always #160 pins_o.pclk = pins_o.pclk ^ pclk_en_i;
    always #640 pins_o.lval = pins_o.lval ^ lval_en_i;
endmodule : clsc_cam_model
`default_nettype wire

// ### clsc_tb_top.sv
// Directed test of lamps, camera power and camera controls.
`timescale 1ns/1ns
`default_nettype none
module clsc_tb_top;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, image_loaded_i = 1'b0, safe_image_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic [1:0] acq_active_i = 2'h0, cam_power_o;
    logic [3:0] cc_o;
    logic line_trig_o;
    logic [5:0] en = 6'h00;
    clsc_pkg::clsc_link_stat_t link_i = '0;
    clsc_pkg::clsc_cam_pins_t cam_i;
    clsc_pkg::clsc_rgb_t board_lamp_o, first_camera_lamp_o, second_camera_lamp_o;
    int num_errors = 0, cmp_count = 0;
    wire logic [4:0] probe = {cc_o[1:0], line_trig_o, first_camera_lamp_o.green, board_lamp_o.green};
    clsc_top #(.SLOW_HALF_CYC(8), .FAST_HALF_CYC(2), .LVAL_TIMEOUT_CYC(50)) i_dut (.*);
    clsc_cam_model i_cam (.pclk_en_i(en[2:0]), .lval_en_i(en[5:3]), .pins_o(cam_i));
    initial forever #20 clk_i = ~clk_i;
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, e);
    endtask : rd
    task automatic board(input logic [10:0] s, input int n);
        @(posedge clk_i);
        {image_loaded_i, safe_image_i, link_i} <= s;
        repeat (n) @(posedge clk_i);
        #1;
    endtask : board
    task automatic flips(input int i, input int n, input logic [31:0] e);
        logic p;
        int k;
        k = 0;
        @(posedge clk_i);
        #1 p = probe[i];
        repeat (n)
        begin
            @(posedge clk_i);
            #1 k += int'(probe[i] !== p);
            p = probe[i];
        end
        check(32'(k), e);
    endtask : flips
    task automatic finish_test();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        #200000 num_errors++;
        finish_test();
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(8'h00, 32'h1);
        rd(8'hfc, 32'h0);
        wr(8'h00, 32'h6);
        wr(8'h00, 32'h2);
        #1 check(32'(cam_power_o), 32'h1);
        board(11'h164, 3);
        check(32'(board_lamp_o), 32'h4);
        board(11'h564, 3);
        check(32'(board_lamp_o), 32'h2);
        board(11'h561, 3);
        check(32'(board_lamp_o), 32'h6);
        board(11'h761, 3);
        check(32'(board_lamp_o), 32'h1);
        board(11'h4e4, 20);
        check(32'(board_lamp_o[1:0]), 32'h0);
        board(11'h544, 2);
        flips(0, 16, 32'h2);
        en <= 6'h03;
        repeat (30) @(posedge clk_i);
        #1 check(32'({first_camera_lamp_o, second_camera_lamp_o}), 32'h14);
        en <= 6'h07;
        repeat (30) @(posedge clk_i);
        #1 check(32'(second_camera_lamp_o), 32'h2);
        wr(8'h00, 32'h0);
        en <= 6'h3f;
        repeat (60) @(posedge clk_i);
        #1 check(32'(second_camera_lamp_o), 32'h4);
        flips(1, 16, 32'h2);
        @(posedge clk_i);
        acq_active_i <= 2'h1;
        flips(1, 16, 32'h8);
        wr(8'h08, 32'h8d1);
        wr(8'h10, 32'h00020001);
        wr(8'h0c, 32'h4);
        repeat (10) @(posedge clk_i);
        #1 check(32'(cc_o[3:2]), 32'h1);
        flips(2, 40, 32'h14);
        flips(3, 40, 32'h14);
        flips(4, 40, 32'h0);
        finish_test();
    end
endmodule : clsc_tb_top
bind clsc_top clsc_checker i_chk (.*);
`default_nettype wire
